// ---- inc/acg_pkg.sv ----
// Constants, types and register map of the offset and gain correction block
// =============================================================================
// What this block does
// - Each sample is chop-averaged when chop is on, offset-subtracted, gain-scaled, then formatted.
// - Offset-corrected value is multiplied by gain coefficient over 16384.
// - Gain 0x5555 is nominal and maps a 0.75 span to full scale.
// - Offset coefficient is 16-bit two's complement spanning one; zero removes nothing.
// - Scaled value is rounded, clamped to 16 bits, output bipolar or unipolar.
// - Coefficients load per-part factory values at power-on.
// - A calibration mode runs a cycle and overwrites the matching coefficient.
// - Self calibration uses internal zero for offset, internal full scale for gain.
// - Offset calibration lasts three output periods, two with chop; then idle.
// - Gain calibration runs two stages, twice the offset duration.
// - Calibration start aborts conversion, uses filter rate, always ends idle.
// - Filter register bit fifteen enables chopping to minimise internal offset.
// - System zero-scale stores offset; system full-scale stores gain.
// - Offset term is scaled by K from the input gain stage setting.
`default_nettype none

package acg_pkg;

    // ==========================================================================
    // Register map
    localparam logic [2:0] ACG_A_MODE = 3'h0;
    localparam logic [2:0] ACG_A_FILT = 3'h1;
    localparam logic [2:0] ACG_A_OFF = 3'h2;
    localparam logic [2:0] ACG_A_GAIN = 3'h3;
    localparam logic [2:0] ACG_A_RES = 3'h4;
    localparam logic [2:0] ACG_A_STAT = 3'h5;
    localparam logic [2:0] ACG_A_SEL = 3'h6;
    localparam logic [15:0] ACG_FILT_RST = 16'h0007;
    localparam logic [4:0] ACG_SEL_RST = 5'h00;
    localparam int ACG_SEL_UNI_BIT = 4;
    localparam int ACG_STAT_RDY_BIT = 0;
    localparam int ACG_STAT_CONV_BIT = 1;
    localparam int ACG_STAT_CAL_BIT = 2;
    localparam int ACG_STAT_STAGE_BIT = 3;

    // ==========================================================================
    // Converter modes
    localparam logic [2:0] ACG_M_IDLE = 3'h0;
    localparam logic [2:0] ACG_M_CONT = 3'h1;
    localparam logic [2:0] ACG_M_SINGLE = 3'h2;
    localparam logic [2:0] ACG_M_SELF_OFF = 3'h4;
    localparam logic [2:0] ACG_M_SELF_GAIN = 3'h5;
    localparam logic [2:0] ACG_M_SYS_OFF = 3'h6;
    localparam logic [2:0] ACG_M_SYS_GAIN = 3'h7;

    // ==========================================================================
    // Arithmetic and calibration constants
    localparam logic [15:0] ACG_GAIN_NOM = 16'h5555;
    localparam int ACG_GAIN_FRAC = 14;
    localparam logic signed [36:0] ACG_RND = 37'sh0000002000;
    localparam logic signed [36:0] ACG_LIM_HI = 37'sh0000007fff;
    localparam logic signed [36:0] ACG_LIM_LO = -37'sh0000008000;
    localparam logic [15:0] ACG_FS_POS = 16'h7fff;
    localparam logic [15:0] ACG_FS_NEG = 16'h8000;
    localparam logic [15:0] ACG_UNI_FLIP = 16'h8000;
    localparam logic [2:0] ACG_PER_NOCHOP = 3'h3;
    localparam logic [2:0] ACG_PER_CHOP = 3'h2;
    localparam logic [29:0] ACG_DIV_NUM = 30'h1fffc000;
    localparam logic [4:0] ACG_DIV_STEPS = 5'h1e;
    localparam logic [15:0] ACG_GAIN_SAT = 16'hffff;

    // ==========================================================================
    // Carriers
    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } acg_bus_s;

    typedef struct packed {
        logic chop;
        logic run_avg;
        logic [5:0] averaging_factor;
        logic sinc_modify;
        logic [6:0] decimation_factor;
    } acg_flt_s;

    typedef enum logic [3:0] {
        ACG_ST_IDLE = 4'b0001,
        ACG_ST_CONV = 4'b0010,
        ACG_ST_CAL = 4'b0100,
        ACG_ST_DIV = 4'b1000
    } acg_state_e;

endpackage : acg_pkg

`default_nettype wire

// ---- verilog/acg_div.sv ----
// Serial restoring divider used to compute the gain coefficient
`default_nettype none

module acg_div (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Operands
    input wire logic start,
    input wire logic [29:0] num,
    input wire logic [16:0] den,
    // Result
    output logic done,
    output logic [29:0] quot
);

    logic [16:0] rem_reg, rem_next;
    logic [29:0] q_reg, q_next;
    logic [16:0] den_reg, den_next;
    logic [4:0] cnt_reg, cnt_next;
    logic done_reg, done_next;
    logic [17:0] shifted;
    logic [18:0] trial;

    // ==========================================================================
    // One quotient bit per cycle, MSB first
    always_comb begin
        rem_next = rem_reg;
        q_next = q_reg;
        den_next = den_reg;
        cnt_next = cnt_reg;
        done_next = 1'b0;
        shifted = {rem_reg, q_reg[29]};
        trial = {1'b0, shifted} - {2'b00, den_reg};
        if (start) begin
            rem_next = 17'h00000;
            q_next = num;
            den_next = den;
            cnt_next = acg_pkg::ACG_DIV_STEPS;
        end else if (cnt_reg != 5'h00) begin
            cnt_next = cnt_reg - 5'h01;
            done_next = (cnt_reg == 5'h01);
            if (!trial[18]) begin
                rem_next = trial[16:0];
                q_next = {q_reg[28:0], 1'b1};
            end else begin
                rem_next = shifted[16:0];
                q_next = {q_reg[28:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rem_reg <= 17'h00000;
            q_reg <= 30'h00000000;
            den_reg <= 17'h00000;
            cnt_reg <= 5'h00;
            done_reg <= 1'b0;
        end else begin
            rem_reg <= rem_next;
            q_reg <= q_next;
            den_reg <= den_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;
    assign quot = q_reg;

endmodule : acg_div

`default_nettype wire

// ---- verilog/acg_core.sv ----
// Offset and gain correction path with calibration sequencer
//
// The register addresses and the plain strobed port were decided locally.
`default_nettype none

module acg_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Factory coefficients
    input wire logic [15:0] fact_offset,
    input wire logic [15:0] fact_gain,
    // Register port
    input wire acg_pkg::acg_bus_s bus,
    output logic [15:0] rdata,
    // Decimation filter side
    input wire logic filt_valid,
    input wire logic [15:0] filt_data,
    output var acg_pkg::acg_flt_s filter_config,
    output logic conv_run,
    output logic conv_abort,
    // Analog source and gain stage
    output logic src_zero,
    output logic src_fullscale,
    output logic [3:0] input_gain_stage,
    // Conversion result
    output logic [15:0] current_result,
    output logic result_valid
);

    // ==========================================================================
    // Decoders
    function automatic logic is_cal(input logic [2:0] m);
        return m[2];
    endfunction : is_cal

    function automatic logic is_conv(input logic [2:0] m);
        return (m == acg_pkg::ACG_M_CONT) || (m == acg_pkg::ACG_M_SINGLE);
    endfunction : is_conv

    function automatic logic [1:0] k_shift(input logic [3:0] code);
        case (code)
            4'h1, 4'h7: k_shift = 2'h1;
            4'h8: k_shift = 2'h2;
            4'h9: k_shift = 2'h3;
            default: k_shift = 2'h0;
        endcase
    endfunction : k_shift

    // ==========================================================================
    // State
    acg_pkg::acg_state_e st_reg, st_next;
    logic [2:0] mode_reg, mode_next;
    acg_pkg::acg_flt_s flt_reg, flt_next;
    logic [15:0] off_reg, off_next;
    logic [15:0] gain_reg, gain_next;
    logic [4:0] sel_reg, sel_next;
    logic stage_reg, stage_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [15:0] zero_reg, zero_next;
    logic abort_reg, abort_next;
    logic rdy_reg, rdy_next;
    logic div_start;
    logic [16:0] div_den;
    logic div_done;
    logic [29:0] div_quot;
    logic store_off, store_gain;
    logic [15:0] prev_reg, prev_next;
    logic pair_reg, pair_next;
    logic [15:0] avg_reg, avg_next;
    logic avg_vld_reg, avg_vld_next;
    logic [15:0] res_reg, res_next;
    logic res_vld_reg, res_vld_next;
    logic [15:0] rdata_reg, rdata_next;
    logic mode_wr;
    logic [2:0] per_lim;
    logic [1:0] ksh;
    logic [16:0] sum;
    logic signed [18:0] off_k;
    logic signed [19:0] diff;
    logic signed [36:0] prod;
    logic signed [36:0] rnd;
    logic [15:0] bip;
    logic [16:0] span;

    assign mode_wr = bus.wr && (bus.addr == acg_pkg::ACG_A_MODE);
    assign ksh = k_shift(sel_reg[3:0]);
    // Calibration length follows chop setting
    assign per_lim = flt_reg.chop ? acg_pkg::ACG_PER_CHOP : acg_pkg::ACG_PER_NOCHOP;

    // ==========================================================================
    // Datapath: chop average, offset, gain, clamp, format
    always_comb begin
        prev_next = prev_reg;
        pair_next = pair_reg;
        avg_next = avg_reg;
        avg_vld_next = 1'b0;
        sum = {prev_reg[15], prev_reg} + {filt_data[15], filt_data};
        if (st_next != st_reg) begin
            pair_next = 1'b0;
        end else if (filt_valid && (st_reg == acg_pkg::ACG_ST_CONV || st_reg == acg_pkg::ACG_ST_CAL)) begin
            prev_next = filt_data;
            pair_next = 1'b1;
            if (!flt_reg.chop) begin
                avg_next = filt_data;
                avg_vld_next = 1'b1;
            end else if (pair_reg) begin
                avg_next = sum[16:1];
                avg_vld_next = 1'b1;
            end
        end
    end

    always_comb begin
        off_k = $signed({{3{off_reg[15]}}, off_reg}) <<< ksh;
        diff = $signed({{4{avg_reg[15]}}, avg_reg}) - $signed({off_k[18], off_k});
        prod = diff * $signed({1'b0, gain_reg});
        rnd = (prod + acg_pkg::ACG_RND) >>> acg_pkg::ACG_GAIN_FRAC;
        if (rnd > acg_pkg::ACG_LIM_HI) begin
            bip = acg_pkg::ACG_FS_POS;
        end else if (rnd < acg_pkg::ACG_LIM_LO) begin
            bip = acg_pkg::ACG_FS_NEG;
        end else begin
            bip = rnd[15:0];
        end
        res_next = res_reg;
        res_vld_next = 1'b0;
        if (avg_vld_reg && st_reg == acg_pkg::ACG_ST_CONV) begin
            res_next = sel_reg[acg_pkg::ACG_SEL_UNI_BIT] ? (bip ^ acg_pkg::ACG_UNI_FLIP) : bip;
            res_vld_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_reg <= 16'h0000;
            pair_reg <= 1'b0;
            avg_reg <= 16'h0000;
            avg_vld_reg <= 1'b0;
            res_reg <= 16'h0000;
            res_vld_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            pair_reg <= pair_next;
            avg_reg <= avg_next;
            avg_vld_reg <= avg_vld_next;
            res_reg <= res_next;
            res_vld_reg <= res_vld_next;
        end
    end

    // ==========================================================================
    // Mode sequencer, calibration and registers
    always_comb begin
        st_next = st_reg;
        mode_next = mode_reg;
        flt_next = flt_reg;
        off_next = off_reg;
        gain_next = gain_reg;
        sel_next = sel_reg;
        stage_next = stage_reg;
        cnt_next = cnt_reg;
        zero_next = zero_reg;
        abort_next = 1'b0;
        div_start = 1'b0;
        store_off = 1'b0;
        store_gain = 1'b0;
        span = {avg_reg[15], avg_reg} - {zero_reg[15], zero_reg};
        div_den = span[16] ? 17'h00000 : span;
        if (bus.wr) begin
            if (bus.addr == acg_pkg::ACG_A_FILT) begin
                flt_next = bus.wdata;
            end else if (bus.addr == acg_pkg::ACG_A_SEL) begin
                sel_next = bus.wdata[4:0];
            end else if (bus.addr == acg_pkg::ACG_A_OFF && st_reg == acg_pkg::ACG_ST_IDLE) begin
                off_next = bus.wdata;
            end else if (bus.addr == acg_pkg::ACG_A_GAIN && st_reg == acg_pkg::ACG_ST_IDLE) begin
                gain_next = bus.wdata;
            end
        end
        if (mode_wr) begin
            mode_next = bus.wdata[2:0];
            stage_next = 1'b0;
            cnt_next = 3'h0;
            if (is_cal(bus.wdata[2:0])) begin
                st_next = acg_pkg::ACG_ST_CAL;
                abort_next = (st_reg == acg_pkg::ACG_ST_CONV);
            end else if (is_conv(bus.wdata[2:0])) begin
                st_next = acg_pkg::ACG_ST_CONV;
            end else begin
                st_next = acg_pkg::ACG_ST_IDLE;
                mode_next = acg_pkg::ACG_M_IDLE;
            end
        end else begin
            case (st_reg)
                acg_pkg::ACG_ST_CONV: begin
                    if (res_vld_next && mode_reg == acg_pkg::ACG_M_SINGLE) begin
                        st_next = acg_pkg::ACG_ST_IDLE;
                        mode_next = acg_pkg::ACG_M_IDLE;
                    end
                end
                acg_pkg::ACG_ST_CAL: begin
                    if (avg_vld_reg) begin
                        cnt_next = cnt_reg + 3'h1;
                        if (cnt_reg == per_lim - 3'h1) begin
                            cnt_next = 3'h0;
                            if (!mode_reg[0]) begin
                                store_off = 1'b1;
                                off_next = 16'($signed(avg_reg) >>> ksh);
                                st_next = acg_pkg::ACG_ST_IDLE;
                                mode_next = acg_pkg::ACG_M_IDLE;
                            end else if (!stage_reg) begin
                                stage_next = 1'b1;
                                zero_next = (mode_reg == acg_pkg::ACG_M_SELF_GAIN) ? avg_reg
                                    : off_reg;
                            end else begin
                                div_start = 1'b1;
                                st_next = acg_pkg::ACG_ST_DIV;
                            end
                        end
                    end
                end
                acg_pkg::ACG_ST_DIV: begin
                    if (div_done) begin
                        store_gain = 1'b1;
                        gain_next = (div_quot[29:16] != 14'h0000) ? acg_pkg::ACG_GAIN_SAT
                            : div_quot[15:0];
                        st_next = acg_pkg::ACG_ST_IDLE;
                        mode_next = acg_pkg::ACG_M_IDLE;
                        stage_next = 1'b0;
                    end
                end
                default: begin
                    st_next = acg_pkg::ACG_ST_IDLE;
                end
            endcase
        end
        // New result wins over a read that clears the flag
        rdy_next = rdy_reg;
        if (bus.rd && bus.addr == acg_pkg::ACG_A_RES) begin
            rdy_next = 1'b0;
        end
        if (res_vld_next) begin
            rdy_next = 1'b1;
        end
        if (bus.addr == acg_pkg::ACG_A_MODE) begin
            rdata_next = {13'h0000, mode_reg};
        end else if (bus.addr == acg_pkg::ACG_A_FILT) begin
            rdata_next = flt_reg;
        end else if (bus.addr == acg_pkg::ACG_A_OFF) begin
            rdata_next = off_reg;
        end else if (bus.addr == acg_pkg::ACG_A_GAIN) begin
            rdata_next = gain_reg;
        end else if (bus.addr == acg_pkg::ACG_A_RES) begin
            rdata_next = res_reg;
        end else if (bus.addr == acg_pkg::ACG_A_STAT) begin
            rdata_next = 16'h0000;
            rdata_next[acg_pkg::ACG_STAT_RDY_BIT] = rdy_reg;
            rdata_next[acg_pkg::ACG_STAT_CONV_BIT] = (st_reg == acg_pkg::ACG_ST_CONV);
            rdata_next[acg_pkg::ACG_STAT_CAL_BIT] = (st_reg == acg_pkg::ACG_ST_CAL)
                || (st_reg == acg_pkg::ACG_ST_DIV);
            rdata_next[acg_pkg::ACG_STAT_STAGE_BIT] = stage_reg;
        end else if (bus.addr == acg_pkg::ACG_A_SEL) begin
            rdata_next = {11'h000, sel_reg};
        end else begin
            rdata_next = 16'h0000;
        end
        if (!bus.rd) begin
            rdata_next = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= acg_pkg::ACG_ST_IDLE;
            mode_reg <= acg_pkg::ACG_M_IDLE;
            flt_reg <= acg_pkg::ACG_FILT_RST;
            off_reg <= fact_offset;
            gain_reg <= fact_gain;
            sel_reg <= acg_pkg::ACG_SEL_RST;
            stage_reg <= 1'b0;
            cnt_reg <= 3'h0;
            zero_reg <= 16'h0000;
            abort_reg <= 1'b0;
            rdy_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            st_reg <= st_next;
            mode_reg <= mode_next;
            flt_reg <= flt_next;
            off_reg <= off_next;
            gain_reg <= gain_next;
            sel_reg <= sel_next;
            stage_reg <= stage_next;
            cnt_reg <= cnt_next;
            zero_reg <= zero_next;
            abort_reg <= abort_next;
            rdy_reg <= rdy_next;
            rdata_reg <= rdata_next;
        end
    end

    acg_div u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(div_start),
        .num(acg_pkg::ACG_DIV_NUM),
        .den(div_den),
        .done(div_done),
        .quot(div_quot)
    );

    // ==========================================================================
    // Outputs
    assign rdata = rdata_reg;
    assign filter_config = flt_reg;
    assign conv_run = (st_reg == acg_pkg::ACG_ST_CONV) || (st_reg == acg_pkg::ACG_ST_CAL);
    assign conv_abort = abort_reg;
    // External input is used for system modes
    assign src_zero = (st_reg == acg_pkg::ACG_ST_CAL) && (mode_reg == acg_pkg::ACG_M_SELF_OFF
        || (mode_reg == acg_pkg::ACG_M_SELF_GAIN && !stage_reg));
    assign src_fullscale = (st_reg == acg_pkg::ACG_ST_CAL)
        && mode_reg == acg_pkg::ACG_M_SELF_GAIN && stage_reg;
    assign input_gain_stage = sel_reg[3:0];
    assign current_result = res_reg;
    assign result_valid = res_vld_reg;

    // ==========================================================================
    // Checks
    default clocking acg_cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    cal_ends_idle_a: assert property (store_off || store_gain |=> st_reg == acg_pkg::ACG_ST_IDLE
        && mode_reg == acg_pkg::ACG_M_IDLE) else $error("calibration did not return to idle");
    abort_pulse_a: assert property (st_reg == acg_pkg::ACG_ST_CONV && mode_wr && is_cal(bus.wdata[2:0])
        |=> conv_abort ##1 !conv_abort) else $error("conversion not aborted");
    off_held_a: assert property (!store_off && !(bus.wr && bus.addr == acg_pkg::ACG_A_OFF)
        |=> $stable(off_reg)) else $error("offset changed without cause");
    coef_lock_a: assert property (st_reg != acg_pkg::ACG_ST_IDLE && !store_gain
        |=> $stable(gain_reg)) else $error("gain written while busy");
    off_cal_len_a: assert property (store_off |-> avg_vld_reg && cnt_reg == per_lim - 3'h1)
        else $error("offset calibration length wrong");
    gain_stages_a: assert property (div_start |-> stage_reg ##1 st_reg == acg_pkg::ACG_ST_DIV)
        else $error("gain stored before second stage");
    chop_period_a: assert property (flt_reg.chop |-> per_lim == 3'h2)
        else $error("chop period count wrong");
    clamp_hi_a: assert property (avg_vld_reg && st_reg == acg_pkg::ACG_ST_CONV
        && rnd > acg_pkg::ACG_LIM_HI && !sel_reg[acg_pkg::ACG_SEL_UNI_BIT]
        |=> current_result == 16'h7fff) else $error("positive clamp missing");
    self_src_a: assert property (st_reg == acg_pkg::ACG_ST_CAL && mode_reg[1]
        |-> !src_zero && !src_fullscale) else $error("internal source on in system mode");
    order_a: assert property (avg_vld_reg && st_reg == acg_pkg::ACG_ST_CONV |=> result_valid)
        else $error("result not produced after sample");

    off_cal_c: cover property (store_off);
    gain_cal_c: cover property (store_gain);
    abort_c: cover property (conv_abort);
    clamp_c: cover property (avg_vld_reg && rnd < acg_pkg::ACG_LIM_LO);

endmodule : acg_core

`default_nettype wire

// ---- testbench/acg_core_bench.sv ----
// Self-checking bench for the offset and gain correction core
`default_nettype none
module acg_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ========
    // Stimulus, observation and counters
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [15:0] fact_offset = 16'h0123;
    logic [15:0] fact_gain = 16'h5a5a;
    acg_pkg::acg_bus_s bus = '0;
    logic filt_valid = 1'b0;
    logic [15:0] filt_data = 16'h0000;
    logic [15:0] rdata;
    logic [15:0] current_result;
    logic result_valid;
    logic src_zero;
    logic [15:0] off_v;
    logic [15:0] gain_v;
    logic [15:0] rd_v;
    logic [15:0] s;
    logic [15:0] corner [4] = '{16'h6000, 16'ha000, 16'h7fff, 16'h8000};
    int err_total = 0;
    int checked = 0;
    int seed = 32'h6f3156b7;
    int cyc = 0;
    always #12.5 clk_sys = ~clk_sys;
    acg_core acg_core_inst (.clk_sys(clk_sys), .rst(rst), .fact_offset(fact_offset),
        .fact_gain(fact_gain), .bus(bus), .rdata(rdata), .filt_valid(filt_valid),
        .filt_data(filt_data), .filter_config(), .conv_run(), .conv_abort(),
        .src_zero(src_zero), .src_fullscale(), .input_gain_stage(),
        .current_result(current_result), .result_valid(result_valid));
    // ========
    // Expectation, comparison and drivers
    function automatic logic [15:0] model(logic [15:0] x, logic [15:0] o, logic [15:0] g);
        longint p;
        p = ((longint'($signed(x)) - longint'($signed(o))) * longint'(g) + 64'sh2000) >>> 14;
        if (p > 64'sh7fff)
            p = 64'sh7fff;
        if (p < -64'sh8000)
            p = -64'sh8000;
        return p[15:0];
    endfunction : model
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic reg_wr(logic [2:0] a, logic [15:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus <= '0;
    endtask : reg_wr
    task automatic reg_rd(logic [2:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus <= '0;
        #1 d = rdata;
    endtask : reg_rd
    task automatic push(logic [15:0] x, logic [15:0] exp, logic cmp);
        int n;
        @(posedge clk_sys);
        filt_valid <= 1'b1;
        filt_data <= x;
        @(posedge clk_sys);
        filt_valid <= 1'b0;
        filt_data <= ~x;
        for (n = 0; n < 6 && result_valid !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        if (cmp)
            chk("result", exp, result_valid === 1'b1 ? current_result : ~exp);
    endtask : push
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            give_verdict();
        end
    end
    // ========
    // Test sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        reg_rd(acg_pkg::ACG_A_OFF, rd_v);
        chk("offset", 16'h0123, rd_v);
        reg_rd(acg_pkg::ACG_A_GAIN, rd_v);
        chk("gain", 16'h5a5a, rd_v);
        reg_rd(acg_pkg::ACG_A_FILT, rd_v);
        chk("filter", 16'h0007, rd_v);
        reg_rd(3'h7, rd_v);
        chk("unmapped", 16'h0000, rd_v);
        $display("test reset done");
        for (int pass = 0; pass < 2; pass++) begin
            off_v = pass ? 16'($random(seed)) : 16'h0000;
            gain_v = pass ? 16'($random(seed)) : acg_pkg::ACG_GAIN_NOM;
            reg_wr(acg_pkg::ACG_A_MODE, {13'h0000, acg_pkg::ACG_M_IDLE});
            reg_wr(acg_pkg::ACG_A_OFF, off_v);
            reg_wr(acg_pkg::ACG_A_GAIN, gain_v);
            reg_rd(acg_pkg::ACG_A_GAIN, rd_v);
            chk("gain", gain_v, rd_v);
            reg_wr(acg_pkg::ACG_A_MODE, {13'h0000, acg_pkg::ACG_M_CONT});
            reg_wr(acg_pkg::ACG_A_OFF, ~off_v);
            reg_rd(acg_pkg::ACG_A_OFF, rd_v);
            chk("offset", off_v, rd_v);
            for (int i = 0; i < 12; i++) begin
                s = (i < 4) ? corner[i] : 16'($random(seed));
                push(s, model(s, off_v, gain_v), 1'b1);
            end
            $display("test conversion pass %0d done", pass);
        end
        reg_wr(acg_pkg::ACG_A_MODE, {13'h0000, acg_pkg::ACG_M_IDLE});
        reg_wr(acg_pkg::ACG_A_OFF, 16'h0000);
        s = 16'($random(seed)) & 16'h03ff;
        reg_wr(acg_pkg::ACG_A_FILT, 16'h007f);
        reg_wr(acg_pkg::ACG_A_MODE, {13'h0000, acg_pkg::ACG_M_SELF_OFF});
        for (int i = 0; i < 3; i++) begin
            reg_rd(acg_pkg::ACG_A_OFF, rd_v);
            chk("zero source", 16'h0001, {15'h0000, src_zero});
            chk("offset", 16'h0000, rd_v);
            push(s, 16'h0000, 1'b0);
        end
        repeat (4) @(posedge clk_sys);
        reg_rd(acg_pkg::ACG_A_OFF, rd_v);
        chk("offset", s, rd_v);
        reg_rd(acg_pkg::ACG_A_MODE, rd_v);
        chk("mode", 16'h0000, rd_v);
        reg_wr(acg_pkg::ACG_A_GAIN, fact_gain);
        reg_wr(acg_pkg::ACG_A_MODE, {13'h0000, acg_pkg::ACG_M_SELF_GAIN});
        for (int i = 0; i < 6; i++)
            push((i < 3) ? 16'h0000 : 16'h6000, 16'h0000, 1'b0);
        repeat (40) @(posedge clk_sys);
        gain_v = 16'(30'h1fffc000 / 30'h00006000);
        reg_rd(acg_pkg::ACG_A_GAIN, rd_v);
        chk("gain", gain_v, rd_v);
        reg_rd(acg_pkg::ACG_A_MODE, rd_v);
        chk("mode", 16'h0000, rd_v);
        // System calibration: the bench drives the same input at every valid sample of the cycle
        off_v = 16'($random(seed)) & 16'h00ff;
        reg_wr(acg_pkg::ACG_A_MODE, {13'h0000, acg_pkg::ACG_M_SYS_OFF});
        for (int i = 0; i < 3; i++) begin
            reg_rd(acg_pkg::ACG_A_STAT, rd_v);
            chk("busy", 16'h0004, rd_v & 16'h0004);
            chk("system source", 16'h0000, {15'h0000, src_zero});
            push(off_v, 16'h0000, 1'b0);
        end
        repeat (4) @(posedge clk_sys);
        reg_rd(acg_pkg::ACG_A_OFF, rd_v);
        chk("offset", off_v, rd_v);
        reg_wr(acg_pkg::ACG_A_MODE, {13'h0000, acg_pkg::ACG_M_SYS_GAIN});
        for (int i = 0; i < 6; i++)
            push(16'h6000, 16'h0000, 1'b0);
        repeat (40) @(posedge clk_sys);
        gain_v = 16'(30'h1fffc000 / (30'h00006000 - {14'h0000, off_v}));
        reg_rd(acg_pkg::ACG_A_GAIN, rd_v);
        chk("gain", gain_v, rd_v);
        reg_wr(acg_pkg::ACG_A_MODE, {13'h0000, acg_pkg::ACG_M_SINGLE});
        s = 16'($random(seed));
        push(s, model(s, off_v, gain_v), 1'b1);
        reg_rd(acg_pkg::ACG_A_MODE, rd_v);
        chk("mode", 16'h0000, rd_v);
        $display("test calibration done");
        give_verdict();
    end
endmodule : acg_core_bench
`default_nettype wire
